// [dij_consts.svh]
// Constants for the decrement, increment and jump execution block.
`ifndef DIJ_CONSTS_SVH
`define DIJ_CONSTS_SVH
`define DIJ_OPC_DEC_REG   6'h03
`define DIJ_OPC_DEC_SKIP  6'h0B
`define DIJ_OPC_INC_REG   6'h0A
`define DIJ_JMP_CLASS     3'h5
`define DIJ_OPC_MSB       13
`define DIJ_OPC_LSB       8
`define DIJ_DEST_BIT      7
`define DIJ_ADDR_MSB      6
`define DIJ_JMP_MSB       13
`define DIJ_JMP_LSB       11
`define DIJ_LIT_MSB       10
`define DIJ_LATCH_MSB     4
`define DIJ_LATCH_LSB     3
`define DIJ_PC_RESET      13'h0000
`define DIJ_W_RESET       8'h00
`define DIJ_PHASES        4
`endif

// [dij_pkg.sv]
// Types shared by the decrement, increment and jump execution block.
package dij_pkg;
  typedef logic [13:0] dij_instr_t;
  typedef logic [12:0] dij_pc_t;
  typedef logic [7:0]  dij_data_t;
  typedef logic [6:0]  dij_addr_t;
  typedef logic [1:0]  dij_phase_t;
  typedef enum logic [2:0] {DIJ_OP_NONE, DIJ_OP_DEC, DIJ_OP_DSZ, DIJ_OP_INC,
                            DIJ_OP_JMP} dij_op_e;
endpackage

// [dij_phase_gen.sv]
// Four-phase instruction cycle generator.
`timescale 1ns/1ps
`include "dij_consts.svh"
module dij_phase_gen
  import dij_pkg::*;
(
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  output dij_pkg::dij_phase_t phase_o,
  output logic              last_o
);
  dij_phase_t phase_reg;
  dij_phase_t phase_next;

  always_comb begin
    phase_next = phase_reg + 2'h1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase_o = phase_reg;
  assign last_o  = (phase_reg == 2'(`DIJ_PHASES - 1));
endmodule // dij_phase_gen

// [dij_exec.sv]
// Execution core for decrement, decrement-skip, increment and jump instructions.
// Overview of operation
// - Decrement register computes file value minus one.
// - Destination bit selects working or file register.
// - Decrement register updates zero flag.
// - Four phases: decode, read, process, write.
// - Zero skip result adds one no-operation cycle.
// - Decrement-skip stores result, flags left unchanged.
// - Jump loads literal into counter bits ten-zero.
// - Jump copies latch bits four-three, no flags.
`timescale 1ns/1ps
`include "dij_consts.svh"
module dij_exec
  import dij_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  dij_pkg::dij_instr_t    instr_i,
  input  dij_pkg::dij_data_t     file_rdata_i,
  input  wire logic [4:0]        counter_high_latch_i,
  output dij_pkg::dij_pc_t       program_counter_o,
  output dij_pkg::dij_addr_t     file_addr_o,
  output dij_pkg::dij_data_t     file_wdata_o,
  output logic                   file_we_o,
  output dij_pkg::dij_data_t     work_reg_o,
  output logic                   zero_flag_o,
  output logic [1:0]             phase_o,
  output logic                   nop_cycle_o
);
  import dij_pkg::*;

  // ----------------------------------------------------------------
  // Phase generation
  // ----------------------------------------------------------------
  dij_phase_t phase;
  logic       last;

  dij_phase_gen u_phase (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .phase_o   (phase),
    .last_o    (last)
  );

  // ----------------------------------------------------------------
  // Execution state
  // ----------------------------------------------------------------
  dij_op_e    op_reg,     op_next;
  dij_instr_t ir_reg,     ir_next;
  dij_data_t  opnd_reg,   opnd_next;
  dij_data_t  res_reg,    res_next;
  dij_pc_t    pc_reg,     pc_next;
  dij_data_t  w_reg,      w_next;
  logic       z_reg,      z_next;
  logic       nop_reg,    nop_next;
  logic       we_reg,     we_next;
  dij_data_t  wd_reg,     wd_next;
  dij_addr_t  addr_reg,   addr_next;
  logic       hold_reg,   hold_next;
  logic [1:0] ph_reg;
  dij_op_e    dec_op;

  always_comb begin
    dec_op = DIJ_OP_NONE;
    if (instr_i[`DIJ_JMP_MSB:`DIJ_JMP_LSB] == `DIJ_JMP_CLASS) begin
      dec_op = DIJ_OP_JMP;
    end else begin
      case (instr_i[`DIJ_OPC_MSB:`DIJ_OPC_LSB])
        `DIJ_OPC_DEC_REG:  dec_op = DIJ_OP_DEC;
        `DIJ_OPC_DEC_SKIP: dec_op = DIJ_OP_DSZ;
        `DIJ_OPC_INC_REG:  dec_op = DIJ_OP_INC;
        default:           dec_op = DIJ_OP_NONE;
      endcase
    end
  end

  always_comb begin
    op_next   = op_reg;
    ir_next   = ir_reg;
    opnd_next = opnd_reg;
    res_next  = res_reg;
    pc_next   = pc_reg;
    w_next    = w_reg;
    z_next    = z_reg;
    nop_next  = nop_reg;
    we_next   = 1'b0;
    wd_next   = wd_reg;
    addr_next = addr_reg;
    hold_next = hold_reg;
    case (phase)
      2'h0: begin
        // Decode; a pending no-operation cycle discards the fetched word.
        ir_next   = instr_i;
        op_next   = nop_reg ? DIJ_OP_NONE : dec_op;
        addr_next = instr_i[`DIJ_ADDR_MSB:0];
      end
      2'h1: begin
        opnd_next = file_rdata_i;
      end
      2'h2: begin
        case (op_reg)
          DIJ_OP_DEC, DIJ_OP_DSZ: res_next = opnd_reg - 8'h01;
          DIJ_OP_INC:             res_next = opnd_reg + 8'h01;
          default:                res_next = res_reg;
        endcase
      end
      default: begin
        nop_next  = 1'b0;
        hold_next = 1'b0;
        // The jump target is already loaded, so its refetch cycle must not count past it.
        if (hold_reg) begin
          pc_next = pc_reg;
        end else begin
          pc_next = pc_reg + 13'h0001;
        end
        case (op_reg)
          DIJ_OP_DEC, DIJ_OP_INC, DIJ_OP_DSZ: begin
            if (ir_reg[`DIJ_DEST_BIT]) begin
              we_next = 1'b1;
              wd_next = res_reg;
            end else begin
              w_next = res_reg;
            end
            if (op_reg != DIJ_OP_DSZ) begin
              z_next = (res_reg == 8'h00);
            end
            if (op_reg == DIJ_OP_DSZ) begin
              nop_next = (res_reg == 8'h00);
            end
          end
          DIJ_OP_JMP: begin
            pc_next  = {counter_high_latch_i[`DIJ_LATCH_MSB:`DIJ_LATCH_LSB],
                        ir_reg[`DIJ_LIT_MSB:0]};
            nop_next = 1'b1;
            hold_next = 1'b1;
          end
          default: begin
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      op_reg   <= DIJ_OP_NONE;
      ir_reg   <= 14'h0000;
      opnd_reg <= 8'h00;
      res_reg  <= 8'h00;
      pc_reg   <= `DIJ_PC_RESET;
      w_reg    <= `DIJ_W_RESET;
      z_reg    <= 1'b0;
      nop_reg  <= 1'b0;
      we_reg   <= 1'b0;
      wd_reg   <= 8'h00;
      addr_reg <= 7'h00;
      hold_reg <= 1'b0;
      ph_reg   <= 2'h0;
    end else begin
      op_reg   <= op_next;
      ir_reg   <= ir_next;
      opnd_reg <= opnd_next;
      res_reg  <= res_next;
      pc_reg   <= pc_next;
      w_reg    <= w_next;
      z_reg    <= z_next;
      nop_reg  <= nop_next;
      we_reg   <= we_next;
      wd_reg   <= wd_next;
      addr_reg <= addr_next;
      hold_reg <= hold_next;
      ph_reg   <= phase;
    end
  end

  assign program_counter_o = pc_reg;
  assign file_addr_o       = addr_reg;
  assign file_wdata_o      = wd_reg;
  assign file_we_o         = we_reg;
  assign work_reg_o        = w_reg;
  assign zero_flag_o       = z_reg;
  assign phase_o           = ph_reg;
  assign nop_cycle_o       = nop_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_DEC_ZERO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase == 2'h3 && op_reg == DIJ_OP_DEC) |=> (z_reg == ($past(res_reg) == 8'h00)))
    else $error("Zero flag wrong after decrement.");
  AST_DSZ_FLAGS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase == 2'h3 && op_reg == DIJ_OP_DSZ) |=> $stable(z_reg))
    else $error("Decrement-skip changed the zero flag.");
  AST_DEST_FILE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase == 2'h3 && op_reg != DIJ_OP_NONE && op_reg != DIJ_OP_JMP && ir_reg[7])
    |=> (file_we_o && file_wdata_o == $past(res_reg)))
    else $error("File write missing for destination one.");
  AST_DEST_W: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase == 2'h3 && op_reg != DIJ_OP_NONE && op_reg != DIJ_OP_JMP && !ir_reg[7])
    |=> (!file_we_o && work_reg_o == $past(res_reg)))
    else $error("Working register not written.");
  AST_DEC_VAL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase == 2'h2 && op_reg == DIJ_OP_DEC) |=> (res_reg == $past(opnd_reg) - 8'h01))
    else $error("Decrement result wrong.");
  AST_INC_VAL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase == 2'h2 && op_reg == DIJ_OP_INC) |=> (res_reg == $past(opnd_reg) + 8'h01))
    else $error("Increment result wrong.");
  AST_JMP_PC: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase == 2'h3 && op_reg == DIJ_OP_JMP) |=> (program_counter_o ==
      {$past(counter_high_latch_i[4:3]), $past(ir_reg[10:0])}))
    else $error("Jump target wrong.");
  AST_JMP_NOP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase == 2'h3 && op_reg == DIJ_OP_JMP) |=> ##1 (op_reg == DIJ_OP_NONE) [*4])
    else $error("Jump did not insert a no-operation cycle.");
  AST_SKIP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase == 2'h3 && op_reg == DIJ_OP_DSZ && res_reg == 8'h00) |=> ##1 (op_reg == DIJ_OP_NONE))
    else $error("Zero result did not skip.");
  AST_PHASE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase == 2'h0) |=> (phase == 2'h1) ##1 (phase == 2'h2) ##1 (phase == 2'h3))
    else $error("Phase order broken.");
  AST_JMP_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase == 2'h3 && op_reg == DIJ_OP_JMP) |=> ##4 $stable(program_counter_o))
    else $error("Counter moved past the jump target.");
  AST_LAST_PHASE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    last |=> (phase == 2'h0))
    else $error("Phase did not wrap after the last phase.");
endmodule // dij_exec

// [dij_fetch_model.sv]
// Program memory and file register model facing the execution block.
`timescale 1ns/1ps
module dij_fetch_model
  import dij_pkg::*;
(
  input  wire logic           ref_clk_i,
  input  dij_pkg::dij_pc_t    pc_i,
  input  dij_pkg::dij_addr_t  addr_i,
  input  dij_pkg::dij_data_t  wdata_i,
  input  wire logic           we_i,
  output dij_pkg::dij_instr_t instr_o,
  output dij_pkg::dij_data_t  rdata_o
);
  dij_instr_t prog [0:8191];
  dij_data_t  file_mem [0:127];
  // Reads are combinational because the core registers both addresses.
  assign instr_o = prog[pc_i];
  assign rdata_o = file_mem[addr_i];
  always @(posedge ref_clk_i) begin
    if (we_i) begin
      file_mem[addr_i] <= wdata_i;
    end
  end
endmodule // dij_fetch_model

// [dij_exec_test.sv]
// Self-checking bench for the execution block.
`timescale 1ns/1ps
`include "dij_consts.svh"
module dij_exec_test;
  import dij_pkg::*;
  typedef struct {dij_data_t w; logic z; dij_pc_t pc; logic nop;
                  logic we; dij_data_t wd; dij_addr_t ad;} dij_exp_s;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  latch = 5'h00;
  logic [31:0] rnd = 32'hB5B8A49F;
  dij_instr_t  instr;
  dij_data_t   rdata, wdata, work;
  dij_pc_t     pc;
  dij_addr_t   addr;
  logic        we, zero, nop;
  logic [1:0]  ph;
  dij_exp_s    q[$];
  dij_exp_s    e;
  dij_instr_t  prog [0:8191];
  dij_data_t   file_ref [0:127];
  int          fails = 0;
  int          num_checks = 0;
  int          ecnt = 0;
  always #12.5 ref_clk = ~ref_clk;
  dij_exec u_dut (.ref_clk_i(ref_clk), .rst_i(rst), .instr_i(instr), .file_rdata_i(rdata),
    .counter_high_latch_i(latch), .program_counter_o(pc), .file_addr_o(addr),
    .file_wdata_o(wdata), .file_we_o(we), .work_reg_o(work), .zero_flag_o(zero),
    .phase_o(ph), .nop_cycle_o(nop));
  dij_fetch_model u_mem (.ref_clk_i(ref_clk), .pc_i(pc), .addr_i(addr), .wdata_i(wdata),
    .we_i(we), .instr_o(instr), .rdata_o(rdata));
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Results settle after every fourth edge, so the watcher keys on its own count.
  always @(posedge ref_clk) begin
    if (rst) begin
      ecnt = 0;
    end else begin
      ecnt = ecnt + 1;
      if (ecnt % 4 == 0) begin
        #1;
        if (q.size() == 0) begin
          chk("pending", 13'h0000, 13'h0001);
        end else begin
          e = q.pop_front();
          chk("work", work, e.w);
          chk("zero", zero, e.z);
          chk("counter", pc, e.pc);
          chk("nop", nop, e.nop);
          chk("we", we, e.we);
          chk("phase", ph, 13'h0003);
          if (e.we) begin
            chk("wdata", wdata, e.wd);
            chk("addr", addr, e.ad);
          end
        end
      end
    end
  end
  initial begin
    int i;
    dij_instr_t ins;
    dij_data_t r, rw;
    dij_pc_t rpc;
    logic rz, rn, rj;
    dij_exp_s ex;
    for (i = 0; i < 8192; i++) begin
      rnd = step(rnd);
      case (rnd[31:29] % 5)
        0: ins = {`DIJ_OPC_DEC_REG, rnd[7:0]};
        1: ins = {`DIJ_OPC_DEC_SKIP, rnd[7:0]};
        2: ins = {`DIJ_OPC_INC_REG, rnd[7:0]};
        3: ins = {`DIJ_JMP_CLASS, rnd[10:0]};
        default: ins = {6'h00, rnd[7:0]};
      endcase
      prog[i] = ins;
      u_mem.prog[i] = ins;
    end
    // Small values make zero results and wrap-around common.
    for (i = 0; i < 128; i++) begin
      rnd = step(rnd);
      file_ref[i] = (rnd[1:0] == 2'h3) ? 8'hFF : {6'h00, rnd[1:0]};
      u_mem.file_mem[i] = file_ref[i];
    end
    {rpc, rw, rz, rn, rj} = '0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 400; i++) begin
      rnd = step(rnd);
      latch <= rnd[4:0];
      ins = prog[rpc];
      ex.we = 1'b0;
      ex.wd = 8'h00;
      ex.ad = 7'h00;
      if (rn) begin
        rn = 1'b0;
        // A jump's refetch cycle stays on the target; a skip moves past the dropped word.
        if (!rj) begin
          rpc++;
        end
        rj = 1'b0;
      end else if (ins[13:11] == `DIJ_JMP_CLASS) begin
        rpc = {rnd[4:3], ins[10:0]};
        rn = 1'b1;
        rj = 1'b1;
      end else begin
        rpc++;
        r = file_ref[ins[6:0]] - 8'h01;
        if (ins[13:8] == `DIJ_OPC_INC_REG) begin
          r = file_ref[ins[6:0]] + 8'h01;
        end
        if (ins[13:8] inside {`DIJ_OPC_DEC_REG, `DIJ_OPC_DEC_SKIP, `DIJ_OPC_INC_REG}) begin
          if (ins[13:8] == `DIJ_OPC_DEC_SKIP) begin
            rn = (r == 8'h00);
          end else begin
            rz = (r == 8'h00);
          end
          if (ins[7]) begin
            file_ref[ins[6:0]] = r;
            ex.we = 1'b1;
            ex.wd = r;
            ex.ad = ins[6:0];
          end else begin
            rw = r;
          end
        end
      end
      ex.w = rw;
      ex.z = rz;
      ex.pc = rpc;
      ex.nop = rn;
      q.push_back(ex);
      repeat (4) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
    wrap_up();
  end
endmodule // dij_exec_test
